// File: design/ccs_phase_timer.sv
/*
  Phase timer: prescaled tick, count in tenths of a minute, and an
  expiry flag against the limit. Assumes clear is a same-clock level.
*/
`timescale 1ns/10ps
`default_nettype none
module ccs_phase_timer #(
  parameter int unsigned TICK_CYC = 32'(ccs_pkg::TICK_CYC)
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  // sequencer side
  ccs_tmr_if.tmr    tmr
);

  typedef struct packed {
    logic [31:0] pre;
    logic [11:0] cnt;
    logic        exp;
  } ccs_tmr_st_type;

  ccs_tmr_st_type st_r;
  ccs_tmr_st_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (tmr.clear) begin
      st_nxt = '0;
    end else begin
      st_nxt.exp = (st_r.cnt >= tmr.limit);
      if (st_r.pre == TICK_CYC - 32'd1) begin
        st_nxt.pre = 32'h0000_0000;
        // saturate rather than wrap back into a short count
        if (st_r.cnt != 12'hfff) begin
          st_nxt.cnt = st_r.cnt + 12'h001;
        end
      end else begin
        st_nxt.pre = st_r.pre + 32'd1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tmr.count   = st_r.cnt;
  assign tmr.expired = st_r.exp;

endmodule
`default_nettype wire

// File: design/ccs_sequencer.sv
/*
  Cell charge sequencer: comparator flags in, phase machine, charge
  drive and open-drain status indicator out, small register port.
  Assumes comparator flags are asynchronous levels from the analog
  front end and nrst_i is held low while supply is below lockout.
*/
`timescale 1ns/10ps
`default_nettype none
module ccs_sequencer #(
  parameter int unsigned TICK_CYC  = 32'(ccs_pkg::TICK_CYC),
  parameter int unsigned BLINK_CYC = 32'(ccs_pkg::BLINK_CYC)
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  // comparator flags
  input  wire logic       cell_above_low_i,
  input  wire logic       cell_detect_i,
  input  wire logic       cell_open_i,
  input  wire logic       temp_in_range_i,
  input  wire logic       over_temp_i,
  input  wire logic       temp_slope_i,
  input  wire logic       disch_set_i,
  input  wire logic       disch_clear_i,
  // straps
  input  wire logic       mode_select_i,
  input  wire logic       timeout_float_i,
  input  wire logic [3:0] timeout_sel_i,
  // register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // charge drive
  output logic            charge_drive_en_o,
  output logic            charge_drive_reduced_o,
  output logic            charge_drive_linear_o,
  output logic            charge_drive_full_on_o,
  // status indicator, open drain
  output logic            status_ind_o,
  output logic            status_ind_oe_o,
  // interrupt
  output logic            irq_o
);

  typedef struct packed {
    logic [13:0]           s1;
    logic [13:0]           s2;
    ccs_pkg::ccs_phase_type ph;
    logic [1:0]            ctrl;
    logic [3:0]            ist;
    logic [3:0]            imsk;
    logic [31:0]           bcnt;
    logic [2:0]            bph;
    logic [7:0]            rdata;
    logic                  drv_en;
    logic                  drv_red;
    logic                  drv_lin;
    logic                  drv_full;
    logic                  ind_oe;
    logic                  irq;
  } ccs_seq_st_type;

  ccs_seq_st_type st_r;
  ccs_seq_st_type st_nxt;
  ccs_tmr_if      tif ();

  logic f_low, f_det, f_open, f_tok, f_ovt;
  logic f_slope, f_dset, f_drst, f_mode, f_susp;
  logic [3:0] f_sel;

  // ---------------------------------------------------------------
  // flags, read only after the second flop
  // ---------------------------------------------------------------
  assign f_low   = st_r.s2[ccs_pkg::F_LOW];
  assign f_det   = st_r.s2[ccs_pkg::F_DET];
  assign f_open  = st_r.s2[ccs_pkg::F_OPEN];
  assign f_tok   = st_r.s2[ccs_pkg::F_TOK];
  assign f_ovt   = st_r.s2[ccs_pkg::F_OVT];
  assign f_slope = st_r.s2[ccs_pkg::F_SLOPE];
  assign f_dset  = st_r.s2[ccs_pkg::F_DSET];
  assign f_drst  = st_r.s2[ccs_pkg::F_DRST];
  assign f_mode  = st_r.s2[ccs_pkg::F_MODE];
  assign f_sel   = st_r.s2[ccs_pkg::F_SEL +: 4];
  // floating timeout pin or software request both suspend
  assign f_susp  = st_r.s2[ccs_pkg::F_RTF] | st_r.ctrl[ccs_pkg::C_SUSP];

  // ---------------------------------------------------------------
  // timer limits
  // ---------------------------------------------------------------
  function automatic logic [11:0] bulk_limit(input logic [3:0] sel);
    logic [15:0] p;
    p = 16'(ccs_pkg::BULK_STEP_T) * ({12'h000, sel} + 16'h0001);
    if (p > 16'(ccs_pkg::BULK_MAX_T)) begin
      p = 16'(ccs_pkg::BULK_MAX_T);
    end
    return p[11:0];
  endfunction

  function automatic logic is_charging(input ccs_pkg::ccs_phase_type p);
    return (p == ccs_pkg::PH_COND) || (p == ccs_pkg::PH_BULK) ||
           (p == ccs_pkg::PH_FIN);
  endfunction

  ccs_phase_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .tmr       (tif.tmr)
  );

  // one timer restarts on every phase change
  assign tif.clear = (st_nxt.ph != st_r.ph);

  always_comb begin
    case (st_nxt.ph)
      ccs_pkg::PH_COND: tif.limit = ccs_pkg::COND_TO_T;
      ccs_pkg::PH_BULK: tif.limit = bulk_limit(f_sel);
      ccs_pkg::PH_FIN: begin
        if (st_r.ctrl[ccs_pkg::C_QTR]) begin
          tif.limit = bulk_limit(f_sel) >> 2;
        end else begin
          tif.limit = bulk_limit(f_sel) >> 1;
        end
      end
      default: tif.limit = ccs_pkg::NO_LIMIT_T;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] ev;
    logic [3:0] w1c;
    logic       chg;
    ev     = 4'h0;
    w1c    = 4'h0;
    chg    = 1'b0;
    st_nxt = st_r;
    st_nxt.s1 = {timeout_sel_i, timeout_float_i, mode_select_i,
                 disch_clear_i, disch_set_i, temp_slope_i, over_temp_i,
                 temp_in_range_i, cell_open_i, cell_detect_i,
                 cell_above_low_i};
    st_nxt.s2 = st_r.s1;

    if (reg_wr_i) begin
      if (reg_addr_i == ccs_pkg::A_CTRL) begin
        st_nxt.ctrl = reg_wdata_i[1:0];
      end else if (reg_addr_i == ccs_pkg::A_ISTAT) begin
        w1c = reg_wdata_i[3:0];
      end else if (reg_addr_i == ccs_pkg::A_IMASK) begin
        st_nxt.imsk = reg_wdata_i[3:0];
      end
    end

    if (st_r.ph == ccs_pkg::PH_DISCH) begin
      if (f_drst) begin
        st_nxt.ph = ccs_pkg::PH_PRES;
      end
    end else if (f_dset) begin
      st_nxt.ph = ccs_pkg::PH_DISCH;
    end else if (f_susp && st_r.ph != ccs_pkg::PH_FAULT) begin
      st_nxt.ph = ccs_pkg::PH_PRES;
    end else begin
      case (st_r.ph)
        ccs_pkg::PH_PRES: begin
          // pack present at power-up is seen here just as an insertion
          if (f_det && f_tok) begin
            st_nxt.ph = ccs_pkg::PH_COND;
          end
        end
        ccs_pkg::PH_COND: begin
          if (f_open) begin
            st_nxt.ph = ccs_pkg::PH_PRES;
          end else if (f_ovt) begin
            st_nxt.ph = ccs_pkg::PH_FAULT;
          end else if (f_low) begin
            st_nxt.ph = ccs_pkg::PH_BULK;
          end else if (tif.expired) begin
            st_nxt.ph = ccs_pkg::PH_FAULT;
          end
        end
        ccs_pkg::PH_BULK: begin
          if (f_open) begin
            st_nxt.ph = ccs_pkg::PH_PRES;
          end else if (f_ovt) begin
            st_nxt.ph = ccs_pkg::PH_DONE;
          end else if (f_slope && tif.count >= ccs_pkg::BLANK_T) begin
            st_nxt.ph = ccs_pkg::PH_FIN;
          end else if (tif.expired) begin
            st_nxt.ph = ccs_pkg::PH_FIN;
          end
        end
        ccs_pkg::PH_FIN: begin
          if (f_open) begin
            st_nxt.ph = ccs_pkg::PH_PRES;
          end else if (f_ovt || tif.expired) begin
            st_nxt.ph = ccs_pkg::PH_DONE;
          end
        end
        ccs_pkg::PH_DONE, ccs_pkg::PH_FAULT: begin
          if (f_open) begin
            st_nxt.ph = ccs_pkg::PH_PRES;
          end
        end
        default: st_nxt.ph = ccs_pkg::PH_PRES;
      endcase
    end

    // status events; a new event beats a clear in the same cycle
    if (st_nxt.ph != st_r.ph) begin
      ev[ccs_pkg::I_PHASE] = 1'b1;
      ev[ccs_pkg::I_FAULT] = (st_nxt.ph == ccs_pkg::PH_FAULT);
      ev[ccs_pkg::I_DONE]  = (st_nxt.ph == ccs_pkg::PH_DONE);
      ev[ccs_pkg::I_DISCH] = (st_nxt.ph == ccs_pkg::PH_DISCH);
    end
    st_nxt.ist = (st_r.ist & ~w1c) | ev;
    st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);

    // blink base: bph[0] gives 4 Hz, bph[2] gives 1 Hz
    if (st_r.bcnt == BLINK_CYC - 32'd1) begin
      st_nxt.bcnt = 32'h0000_0000;
      st_nxt.bph  = st_r.bph + 3'h1;
    end else begin
      st_nxt.bcnt = st_r.bcnt + 32'd1;
    end

    chg = is_charging(st_nxt.ph);
    st_nxt.drv_en   = chg;
    st_nxt.drv_red  = (st_nxt.ph == ccs_pkg::PH_COND) ||
                      (st_nxt.ph == ccs_pkg::PH_FIN);
    st_nxt.drv_lin  = ~f_mode;
    st_nxt.drv_full = (st_nxt.ph == ccs_pkg::PH_DISCH);
    if (chg) begin
      st_nxt.ind_oe = ~st_nxt.bph[2];
    end else if (st_nxt.ph == ccs_pkg::PH_FAULT) begin
      st_nxt.ind_oe = ~st_nxt.bph[0];
    end else begin
      st_nxt.ind_oe = 1'b0;
    end

    st_nxt.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == ccs_pkg::A_CTRL) begin
        st_nxt.rdata = {6'h00, st_r.ctrl};
      end else if (reg_addr_i == ccs_pkg::A_PHASE) begin
        st_nxt.rdata = {1'b0, st_r.ph};
      end else if (reg_addr_i == ccs_pkg::A_ISTAT) begin
        st_nxt.rdata = {4'h0, st_r.ist};
      end else if (reg_addr_i == ccs_pkg::A_IMASK) begin
        st_nxt.rdata = {4'h0, st_r.imsk};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_r      <= '0;
      st_r.ph   <= ccs_pkg::PH_PRES;
      st_r.ctrl <= ccs_pkg::CTRL_RST;
      st_r.imsk <= ccs_pkg::IMASK_RST;
      st_r.drv_lin <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o            = st_r.rdata;
  assign charge_drive_en_o      = st_r.drv_en;
  assign charge_drive_reduced_o = st_r.drv_red;
  assign charge_drive_linear_o  = st_r.drv_lin;
  assign charge_drive_full_on_o = st_r.drv_full;
  assign status_ind_o           = 1'b0;
  assign status_ind_oe_o        = st_r.ind_oe;
  assign irq_o                  = st_r.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic quiet;
  assign quiet = !f_open && !f_dset && !f_susp;

  sequence cond_ready_s;
    st_r.ph == ccs_pkg::PH_COND && f_low && !f_ovt && quiet;
  endsequence

  sequence bulk_entered_s;
    st_r.ph == ccs_pkg::PH_BULK ##1 charge_drive_reduced_o == 1'b0;
  endsequence

  pres_start_a: assert property (
    st_r.ph == ccs_pkg::PH_PRES && f_det && f_tok && quiet
    |=> st_r.ph == ccs_pkg::PH_COND)
    else $error("presence did not start conditioning");

  bulk_after_cond_a: assert property (
    $rose(st_r.ph == ccs_pkg::PH_BULK)
    |-> $past(st_r.ph) == ccs_pkg::PH_COND)
    else $error("bulk entered without conditioning");

  cond_to_bulk_a: assert property (
    cond_ready_s |=> bulk_entered_s)
    else $error("conditioning did not advance to full-rate bulk");

  bulk_ovt_done_a: assert property (
    st_r.ph == ccs_pkg::PH_BULK && f_ovt && quiet
    |=> st_r.ph == ccs_pkg::PH_DONE ##1 !charge_drive_en_o)
    else $error("over-temperature in bulk did not end in done");

  slope_blank_a: assert property (
    st_r.ph == ccs_pkg::PH_BULK && tif.count < ccs_pkg::BLANK_T &&
    !tif.expired |=> st_r.ph != ccs_pkg::PH_FIN)
    else $error("slope acted during blanking");

  slope_finish_a: assert property (
    st_r.ph == ccs_pkg::PH_BULK && f_slope && !f_ovt && quiet &&
    tif.count >= ccs_pkg::BLANK_T |=> st_r.ph == ccs_pkg::PH_FIN)
    else $error("slope trip did not start finishing");

  done_hold_a: assert property (
    st_r.ph == ccs_pkg::PH_DONE && quiet
    |=> st_r.ph == ccs_pkg::PH_DONE)
    else $error("done left without cause");

  disch_entry_a: assert property (
    st_r.ph != ccs_pkg::PH_DISCH && f_dset
    |=> st_r.ph == ccs_pkg::PH_DISCH && charge_drive_full_on_o)
    else $error("discharge not entered");

  disch_drive_a: assert property (
    st_r.ph == ccs_pkg::PH_DISCH
    |-> charge_drive_full_on_o && !charge_drive_en_o &&
        !status_ind_oe_o)
    else $error("discharge drive wrong");

  mode_sel_a: assert property (
    $changed(f_mode) |=> charge_drive_linear_o == !$past(f_mode))
    else $error("regulation mode does not follow strap");

  open_pres_a: assert property (
    (st_r.ph == ccs_pkg::PH_COND || st_r.ph == ccs_pkg::PH_BULK) &&
    f_open && !f_dset |=> st_r.ph == ccs_pkg::PH_PRES)
    else $error("open cell did not return to presence");

  cond_timeout_a: assert property (
    st_r.ph == ccs_pkg::PH_COND && tif.expired && !f_low && !f_ovt &&
    quiet |=> st_r.ph == ccs_pkg::PH_FAULT)
    else $error("conditioning timeout did not fault");

  ind_drain_a: assert property (
    !is_charging(st_r.ph) && st_r.ph != ccs_pkg::PH_FAULT
    |-> !status_ind_oe_o && status_ind_o == 1'b0)
    else $error("indicator driven outside charge or fault");

endmodule
`default_nettype wire

// File: pkg/ccs_pkg.sv
/*
  Shared constants for the cell charge sequencer: time base, phase
  timer limits, comparator flag positions, register map and phases.
  Assumes a single 250 MHz clock.
*/
`default_nettype none
package ccs_pkg;

  // ---------------------------------------------------------------
  // time base
  // ---------------------------------------------------------------
  localparam longint CLK_KHZ   = 250000;
  localparam longint TICK_MS   = 6000;  // one tenth of a minute
  localparam longint TICK_CYC  = TICK_MS * CLK_KHZ;
  localparam longint BLINK_MS  = 125;
  localparam longint BLINK_CYC = BLINK_MS * CLK_KHZ;

  // ---------------------------------------------------------------
  // phase limits, in tenths of a minute
  // ---------------------------------------------------------------
  localparam int          TW          = 12;
  localparam logic [11:0] BLANK_T     = 12'h02b;  // 4.3 min
  localparam logic [11:0] COND_TO_T   = 12'h12c;  // 30 min
  localparam logic [11:0] BULK_STEP_T = 12'h12c;  // 30 min
  localparam logic [11:0] BULK_MAX_T  = 12'he10;  // 6 hours
  localparam logic [11:0] NO_LIMIT_T  = 12'hfff;

  // ---------------------------------------------------------------
  // synchronised flag positions
  // ---------------------------------------------------------------
  localparam int F_LOW   = 0;
  localparam int F_DET   = 1;
  localparam int F_OPEN  = 2;
  localparam int F_TOK   = 3;
  localparam int F_OVT   = 4;
  localparam int F_SLOPE = 5;
  localparam int F_DSET  = 6;
  localparam int F_DRST  = 7;
  localparam int F_MODE  = 8;
  localparam int F_RTF   = 9;
  localparam int F_SEL   = 10;
  localparam int NSYNC   = 14;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] A_CTRL    = 4'h0;
  localparam logic [3:0] A_PHASE   = 4'h1;
  localparam logic [3:0] A_ISTAT   = 4'h2;
  localparam logic [3:0] A_IMASK   = 4'h3;
  localparam int         C_QTR     = 0;
  localparam int         C_SUSP    = 1;
  localparam logic [1:0] CTRL_RST  = 2'h0;
  localparam int         I_PHASE   = 0;
  localparam int         I_FAULT   = 1;
  localparam int         I_DONE    = 2;
  localparam int         I_DISCH   = 3;
  localparam logic [3:0] IMASK_RST = 4'h0;

  typedef enum logic [6:0] {
    PH_PRES  = 7'h01,
    PH_COND  = 7'h02,
    PH_BULK  = 7'h04,
    PH_FIN   = 7'h08,
    PH_DONE  = 7'h10,
    PH_FAULT = 7'h20,
    PH_DISCH = 7'h40
  } ccs_phase_type;

endpackage
`default_nettype wire

// File: pkg/ccs_tmr_if.sv
/*
  Link between the sequencer and its phase timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface ccs_tmr_if;
  logic        clear;
  logic [11:0] limit;
  logic [11:0] count;
  logic        expired;
  modport ctl (output clear, output limit, input count, input expired);
  modport tmr (input clear, input limit, output count, output expired);
endinterface
`default_nettype wire

// File: test/ccs_pack_model.sv
/*
  Behavioural cell pack with thermistor and sense resistor, seen as the
  comparator flags the sequencer consumes. Assumes the bench commands
  presence, charge level, heat, slope, load and charger push.
*/
`timescale 1ns/10ps
`default_nettype none
module ccs_pack_model (
  // bench commands
  input  wire logic present_i,
  input  wire logic charged_i,
  input  wire logic hot_i,
  input  wire logic slope_i,
  input  wire logic load_i,
  input  wire logic push_i,
  // charger side
  input  wire logic charge_en_i,
  // comparator flags
  output logic      above_low_o,
  output logic      detect_o,
  output logic      open_o,
  output logic      in_range_o,
  output logic      over_temp_o,
  output logic      slope_o,
  output logic      dset_o,
  output logic      dclr_o
);
  // ---------------------------------------------------------------
  // flags
  // ---------------------------------------------------------------
  // an open pack floats high, so it also reads above the low level
  assign above_low_o = !present_i | charged_i;
  assign detect_o    = present_i;
  assign open_o      = !present_i;
  assign in_range_o  = !hot_i;
  assign over_temp_o = hot_i;
  // cells only warm up while current flows
  assign slope_o     = slope_i & charge_en_i;
  assign dset_o      = load_i & present_i;
  assign dclr_o      = push_i;
endmodule
`default_nettype wire

// File: test/tb_top.sv
/*
  Self-checking bench for the cell charge sequencer: a table of pack
  conditions walked in order, then register, interrupt and reset tests.
  Assumes short tick and blink parameters of four cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct {
    logic [7:0] ctl;  // q pres low hot slope load push mode
    int         wt;
    logic [6:0] ph;
    logic [2:0] drv;  // en reduced full_on
  } ccs_row_type;
  localparam logic [6:0] PR = ccs_pkg::PH_PRES;
  localparam logic [6:0] CO = ccs_pkg::PH_COND;
  localparam logic [6:0] BU = ccs_pkg::PH_BULK;
  localparam logic [6:0] FI = ccs_pkg::PH_FIN;
  localparam logic [6:0] DO = ccs_pkg::PH_DONE;
  localparam logic [6:0] FA = ccs_pkg::PH_FAULT;
  localparam logic [6:0] DI = ccs_pkg::PH_DISCH;
  logic       ref_clk_i = 1'h0;
  logic       nrst_i = 1'h0;
  logic [7:0] stim = 8'h00;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'h0;
  logic       reg_rd_i = 1'h0;
  logic [7:0] reg_rdata_o;
  logic       en, red, lin, full, ind, oe, irq;
  logic       f_low, f_det, f_open, f_rng, f_ot, f_sl, f_ds, f_dc;
  int         miscompares = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         cnt;
  logic [3:0] tsel = 4'h0;
  // timings per row leave margin for tick phase and read cycles
  ccs_row_type rows [21] = '{
    '{8'h00, 20, PR, 3'h0}, '{8'h40, 20, CO, 3'h6},
    '{8'h60, 20, BU, 3'h4}, '{8'h68, 100, BU, 3'h4},
    '{8'h68, 100, FI, 3'h6}, '{8'h60, 450, FI, 3'h6},
    '{8'h60, 200, DO, 3'h0}, '{8'h65, 20, DI, 3'h1},
    '{8'h02, 20, PR, 3'h0}, '{8'h40, 1400, FA, 3'h0},
    '{8'h00, 20, PR, 3'h0}, '{8'h40, 20, CO, 3'h6},
    '{8'h60, 20, BU, 3'h4}, '{8'h70, 20, DO, 3'h0},
    '{8'h00, 20, PR, 3'h0}, '{8'he0, 20, BU, 3'h4},
    '{8'he0, 1250, FI, 3'h6}, '{8'he0, 400, DO, 3'h0},
    '{8'h80, 20, PR, 3'h0}, '{8'he0, 20, BU, 3'h4},
    '{8'h80, 20, PR, 3'h0}};

  always #2 ref_clk_i = ~ref_clk_i;

  ccs_pack_model pack (
    .present_i(stim[6]), .charged_i(stim[5]), .hot_i(stim[4]),
    .slope_i(stim[3]), .load_i(stim[2]), .push_i(stim[1]),
    .charge_en_i(en), .above_low_o(f_low), .detect_o(f_det),
    .open_o(f_open), .in_range_o(f_rng), .over_temp_o(f_ot),
    .slope_o(f_sl), .dset_o(f_ds), .dclr_o(f_dc));

  ccs_sequencer #(.TICK_CYC(4), .BLINK_CYC(4)) dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .cell_above_low_i(f_low), .cell_detect_i(f_det),
    .cell_open_i(f_open), .temp_in_range_i(f_rng),
    .over_temp_i(f_ot), .temp_slope_i(f_sl),
    .disch_set_i(f_ds), .disch_clear_i(f_dc),
    .mode_select_i(stim[0]), .timeout_float_i(1'h0),
    .timeout_sel_i(tsel), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .charge_drive_en_o(en), .charge_drive_reduced_o(red),
    .charge_drive_linear_o(lin), .charge_drive_full_on_o(full),
    .status_ind_o(ind), .status_ind_oe_o(oe), .irq_o(irq));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic close_out;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'h0;
  endtask

  task automatic rchk(input string n, input logic [3:0] a,
                      input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'h0;
    #1;
    chk(n, e, reg_rdata_o);
  endtask

  // a hang ends in the same verdict path
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    nrst_i <= 1'h1;
    foreach (rows[i]) begin
      wr(ccs_pkg::A_CTRL, {7'h00, rows[i].ctl[7]});
      stim <= rows[i].ctl;
      cnt = 0;
      for (int k = 0; k < rows[i].wt; k++) begin
        @(posedge ref_clk_i);
        #1;
        if (k >= rows[i].wt - 40) cnt += int'(oe);
      end
      rchk("phase", ccs_pkg::A_PHASE, {1'h0, rows[i].ph});
      chk("drive", {5'h00, rows[i].drv}, {5'h00, en, red, full});
      chk("linear", {7'h00, ~rows[i].ctl[0]}, {7'h00, lin});
      chk("ind", 8'h00, {7'h00, ind});
      if (rows[i].ph inside {PR, DO, DI}) begin
        chk("ind_oe", 8'h00, {7'h00, oe});
      end else if (rows[i].wt >= 100) begin
        chk("blink", 8'h01, {7'h00, cnt > 0 && cnt < 40});
      end
    end
    // a longer timeout setting stretches the bulk span
    @(posedge ref_clk_i);
    tsel <= 4'h1;
    stim <= 8'h60;
    repeat (2300) @(posedge ref_clk_i);
    rchk("span_bulk", ccs_pkg::A_PHASE, {1'h0, BU});
    repeat (200) @(posedge ref_clk_i);
    rchk("span_fin", ccs_pkg::A_PHASE, {1'h0, FI});
    @(posedge ref_clk_i);
    stim <= 8'h80;
    tsel <= 4'h0;
    // sticky events, masking and write-one-to-clear
    rchk("istat", ccs_pkg::A_ISTAT, 8'h0f);
    chk("irq_masked", 8'h00, {7'h00, irq});
    wr(ccs_pkg::A_IMASK, 8'h04);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq_set", 8'h01, {7'h00, irq});
    wr(ccs_pkg::A_ISTAT, 8'h04);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("irq_clr", 8'h00, {7'h00, irq});
    rchk("istat_w1c", ccs_pkg::A_ISTAT, 8'h0b);
    rchk("ctrl", ccs_pkg::A_CTRL, 8'h01);
    wr(4'hf, 8'hff);
    rchk("unmapped", 4'hf, 8'h00);
    rchk("imask", ccs_pkg::A_IMASK, 8'h04);
    // second reset in mid-run
    @(posedge ref_clk_i);
    nrst_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("rst_out", 8'h04, {3'h0, en, red, lin, full, oe | irq});
    @(posedge ref_clk_i);
    nrst_i <= 1'h1;
    rchk("rst_istat", ccs_pkg::A_ISTAT, 8'h00);
    rchk("rst_imask", ccs_pkg::A_IMASK, {4'h0, ccs_pkg::IMASK_RST});
    rchk("rst_phase", ccs_pkg::A_PHASE, {1'h0, PR});
    close_out();
  end
endmodule
`default_nettype wire
